// [verilog/bus_hold_arb.sv]
// Bus hold arbitration, strap capture and memory routing
`timescale 1ns/100ps

// Overview of operation
// R01: Strap routes partition range internal or external
// R02: Strap captured only at reset release
// R03: External strap locks ports to bus
// R04: Ack low once device released bus
// R05: Hold request honoured only when enabled
// R06: Irq-out low when interrupt needs bus
// R07: Internal execution: irq-out immediately while held
// R08: External execution: bus-need, irq-out after release
// R09: Irq while entering hold: ack+irq till release
// R10: Bus-need low when cycle pending, held
// R11: Bus-need stays low until request removed
// R12: Drop ack before resuming; float bus meanwhile
module bus_hold_arb
  import hold_pkg::*;
(
  input wire logic clk,                   // 200 MHz clock
  input wire logic rst,                   // Sync reset, active high
  input wire logic external_access_strap, // Strap pin, async
  input wire logic hold_req_n,            // Outside bus request pin, async
  input wire logic hold_pin_special,      // Pin set for special function
  input wire logic [7:0] window_select_reg, // Window select register value
  input wire logic irq_pending,           // Core has a pending interrupt
  input wire logic exec_external,         // Core executing from external
  input wire mem_req_t mem_req,           // Core memory access
  output mem_route_t mem_route,           // Routing of that access
  output logic bus_release_ack_n,         // Bus released, active low
  output logic bus_need_request_n,        // Bus needed back, active low
  output logic irq_bus_need_out_n,        // Irq needs bus, active low
  output logic bus_out_en,                // Device may drive bus pins
  output logic port_io_allowed,           // Ports 3/4 usable as I/O
  output logic strap_internal             // Latched strap level
);

  // ----------------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------------
  logic [1:0] pins_s;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .pin_in({external_access_strap, hold_req_n}),
    .pin_out(pins_s)
  );

  logic strap_s;
  logic hold_s;
  assign strap_s = pins_s[1];
  assign hold_s = ~pins_s[0];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    arb_state_t state;
    logic rst_d;          // Reset seen last cycle
    logic strap;          // Latched strap level
    logic ack_n;
    logic need_n;
    logic irq_n;
    logic drive_en;
    logic io_ok;
    mem_route_t route;
  } arb_t;

  arb_t st_r;
  arb_t st_nxt;

  logic hold_active;
  logic in_range;
  logic ext_access;

  // Request counts only when pin and protocol are enabled
  assign hold_active = hold_s & hold_pin_special &
                       window_select_reg[HOLD_EN_BIT]; // [R05]

  assign in_range = (mem_req.addr >= STRAP_RANGE_LO) &&
                    (mem_req.addr <= STRAP_RANGE_HI);

  // Access that needs the external bus; internal ones never ask for it
  assign ext_access = mem_req.valid & ~(in_range & st_r.strap); // [R01]

  // Next-state logic for arbitration and routing
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_d = 1'b0;
    // Capture on the first cycle after reset lifts, never later
    if (st_r.rst_d) begin
      st_nxt.strap = strap_s; // [R02]
    end
    // Port I/O only in internal-strap systems with bus idle
    st_nxt.io_ok = st_r.strap & ~mem_req.cycle_busy &
                   (st_r.state == ST_OWN); // [R03]
    // Routing decision; outside range the strap is ignored
    st_nxt.route.to_internal = mem_req.valid & in_range &
                               st_r.strap; // [R01]
    st_nxt.route.to_external = ext_access; // [R01]
    case (st_r.state)
      ST_OWN: begin
        st_nxt.drive_en = 1'b1;
        if (hold_active) begin
          st_nxt.state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (!hold_active) begin
          st_nxt.state = ST_OWN;
        end else if (!mem_req.cycle_busy) begin
          // Never let go mid-cycle, even with an irq waiting
          st_nxt.ack_n = 1'b0; // [R04] [R09]
          st_nxt.drive_en = 1'b0; // [R12]
          if (irq_pending && exec_external) begin
            // Ack and irq-out together, kept until release
            st_nxt.state = ST_EARLY_IRQ;
            st_nxt.irq_n = 1'b0; // [R09]
          end else begin
            st_nxt.state = ST_HELD;
          end
        end
      end
      ST_HELD: begin
        if (!hold_active) begin
          st_nxt.state = ST_RETURN;
          st_nxt.ack_n = 1'b1; // [R12]
          st_nxt.need_n = 1'b1; // [R11]
          // Deferred irq-out shows once the master lets go
          st_nxt.irq_n = ~irq_pending; // [R08]
        end else begin
          // Sticky until the request is removed
          if (ext_access || (irq_pending && exec_external)) begin
            st_nxt.need_n = 1'b0; // [R10] [R08]
          end
          if (irq_pending && !exec_external) begin
            st_nxt.irq_n = 1'b0; // [R07] [R06]
          end
        end
      end
      ST_EARLY_IRQ: begin
        if (!hold_active) begin
          st_nxt.state = ST_RETURN;
          st_nxt.ack_n = 1'b1; // [R09]
          st_nxt.irq_n = ~irq_pending; // [R06]
        end
      end
      ST_RETURN: begin
        // One cycle gap: ack high before own drivers return
        st_nxt.state = ST_OWN;
        st_nxt.drive_en = 1'b1; // [R12]
        st_nxt.irq_n = 1'b1;
      end
      default: begin
        st_nxt.state = ST_OWN;
      end
    endcase
  end

  // Registered state, constant reset values only
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.state <= ST_OWN;
      st_r.rst_d <= 1'b1;
      st_r.strap <= STRAP_RST;
      st_r.ack_n <= 1'b1;
      st_r.need_n <= 1'b1;
      st_r.irq_n <= 1'b1;
      st_r.drive_en <= 1'b0;
      st_r.io_ok <= 1'b0;
      st_r.route <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus_release_ack_n = st_r.ack_n;
  assign bus_need_request_n = st_r.need_n;
  assign irq_bus_need_out_n = st_r.irq_n;
  assign bus_out_en = st_r.drive_en;
  assign port_io_allowed = st_r.io_ok;
  assign strap_internal = st_r.strap;
  assign mem_route = st_r.route;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence going_held_s;
    st_r.state == ST_RELEASE && hold_active && !irq_pending &&
    !mem_req.cycle_busy;
  endsequence

  ack_on_release_a: assert property ( // [R04]
    @(posedge clk) disable iff (rst)
    going_held_s |=> !bus_release_ack_n)
    else $error("ack not given after release");

  no_drive_held_a: assert property ( // [R12]
    @(posedge clk) disable iff (rst)
    !bus_release_ack_n |-> !bus_out_en)
    else $error("bus driven while ack low");

  need_sticky_a: assert property ( // [R11]
    @(posedge clk) disable iff (rst)
    (!bus_need_request_n && hold_active) |=> !bus_need_request_n)
    else $error("bus need dropped while held");

  need_when_held_a: assert property ( // [R10]
    @(posedge clk) disable iff (rst)
    (st_r.state == ST_HELD && hold_active && ext_access)
    |=> !bus_need_request_n)
    else $error("bus need missing");

  irq_internal_a: assert property ( // [R07]
    @(posedge clk) disable iff (rst)
    (st_r.state == ST_HELD && hold_active && irq_pending &&
     !exec_external) |=> !irq_bus_need_out_n)
    else $error("irq out late for internal exec");

  irq_deferred_a: assert property ( // [R08]
    @(posedge clk) disable iff (rst)
    (st_r.state == ST_HELD && hold_active && exec_external &&
     irq_bus_need_out_n) |=> irq_bus_need_out_n)
    else $error("irq out before release");

  early_pair_a: assert property ( // [R09]
    @(posedge clk) disable iff (rst)
    (st_r.state == ST_EARLY_IRQ && hold_active)
    |-> (!bus_release_ack_n && !irq_bus_need_out_n))
    else $error("early irq pair not held");

  strap_fixed_a: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
    !$past(st_r.rst_d) && !st_r.rst_d |-> $stable(strap_internal))
    else $error("strap changed after reset");

  route_a: assert property ( // [R01]
    @(posedge clk) disable iff (rst)
    (mem_req.valid && in_range && !st_r.strap) |=> mem_route.to_external)
    else $error("range not routed external");

  io_lock_a: assert property ( // [R03]
    @(posedge clk) disable iff (rst)
    !strap_internal && !$past(strap_internal) |-> !port_io_allowed)
    else $error("port io with external strap");

  gate_a: assert property ( // [R05]
    @(posedge clk) disable iff (rst)
    (!window_select_reg[HOLD_EN_BIT] && st_r.state == ST_OWN)
    |=> st_r.state == ST_OWN)
    else $error("hold taken while disabled");

endmodule : bus_hold_arb

// [common/hold_pkg.sv]
// Shared constants and carrier types for the bus hold arbitration block
package hold_pkg;

  // ----------------------------------------------------------------------
  // Memory partition steered by the access strap
  // ----------------------------------------------------------------------
  localparam logic [23:0] STRAP_RANGE_LO = 24'hFF2000;
  localparam logic [23:0] STRAP_RANGE_HI = 24'hFF9FFF;

  // ----------------------------------------------------------------------
  // Control fields and reset values
  // ----------------------------------------------------------------------
  localparam int HOLD_EN_BIT = 7;               // Protocol enable in window reg
  localparam logic STRAP_RST = 1'b1;            // Internal until first capture
  localparam logic [1:0] SYNC_RST = 2'h3;       // Pins idle high
  localparam logic [7:0] WIN_RST = 8'h00;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OWN,        // Device owns the bus
    ST_RELEASE,    // Finishing own cycle before letting go
    ST_HELD,       // Outside master holds the bus
    ST_EARLY_IRQ,  // Irq arrived while going into hold
    ST_RETURN      // Ack dropped, bus not yet resumed
  } arb_state_t;

  typedef struct packed {
    logic [23:0] addr;      // Address of the pending access
    logic valid;            // Access request
    logic cycle_busy;       // Own external cycle in flight
  } mem_req_t;

  typedef struct packed {
    logic to_internal;      // Routed to on-chip memory
    logic to_external;      // Routed to external bus
  } mem_route_t;

endpackage : hold_pkg

// [verilog/pin_sync.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pin_sync
  import hold_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk,                 // System clock
  input wire logic rst,                 // Sync reset, active high
  input wire logic [WIDTH-1:0] pin_in,  // Raw pins
  output logic [WIDTH-1:0] pin_out      // Synchronised pins
);

  initial begin
    if (WIDTH < 1) $error("pin_sync WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // First stage feeds only the second stage
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  // No reset on purpose: the pins keep flowing through during reset, so
  // the strap level is already settled at the release edge
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign pin_out = st_r.s2;

  // Two stages, no more, no fewer
  sync_delay_a: assert property ( // [R02]
    @(posedge clk) disable iff (rst)
    pin_out == $past(pin_in, 2))
    else $error("synchroniser latency wrong");

endmodule : pin_sync

// [dv/bus_master_model.sv]
// Outside bus master model that asks for the shared bus
`timescale 1ns/100ps
module bus_master_model (
  input wire logic clk,       // System clock
  input wire logic want_bus,  // Bench wants the bus taken
  output logic hold_req_n     // Request pin, active low
);
  // ------------------------------------------------------------
  // Request pin
  // ------------------------------------------------------------
  // Wish taken at the rising edge, where the bench holds it steady, so the
  // pin never races the bench's own falling-edge writes
  logic want_q = 1'b0;
  initial hold_req_n = 1'b1;
  always @(posedge clk) begin
    want_q <= want_bus;
  end
  // Pin moves only at the falling edge, held until the bench lets go
  always @(negedge clk) begin
    hold_req_n <= ~want_q;
  end
endmodule : bus_master_model

// [dv/bus_hold_arbitration_test.sv]
// Self-checking bench for the bus hold arbitration block
`timescale 1ns/100ps
module bus_hold_arbitration_test;
  import hold_pkg::*;
  typedef struct {string what; int idx; logic exp;} note_t;
  logic clk = 0, rst = 1, strap = 1, want = 0, special = 1;
  logic irq = 0, ext = 0, ack_n, need_n, irq_n, out_en, io, strap_int;
  logic hold_req_n;
  logic [7:0] win = 8'h80;
  logic [7:0] obs;
  logic [31:0] seed = 32'h4;
  mem_req_t req = '0;
  mem_route_t route;
  int errors = 0, total_checks = 0;
  note_t notes[$];
  note_t n;
  event look;

  // ------------------------------------------------------------
  // Clock, design and partner
  // ------------------------------------------------------------
  always #2.5 clk = ~clk;
  // Bit order: to_int 7, to_ext 6, ack 5, need 4, irq 3, oe 2, io 1
  assign obs = {route, ack_n, need_n, irq_n, out_en, io, strap_int};
  bus_master_model i_master (.clk(clk), .want_bus(want),
    .hold_req_n(hold_req_n));
  bus_hold_arb i_dut (.clk(clk), .rst(rst),
    .external_access_strap(strap), .hold_req_n(hold_req_n),
    .hold_pin_special(special), .window_select_reg(win),
    .irq_pending(irq), .exec_external(ext), .mem_req(req),
    .mem_route(route), .bus_release_ack_n(ack_n),
    .bus_need_request_n(need_n), .irq_bus_need_out_n(irq_n),
    .bus_out_en(out_en), .port_io_allowed(io), .strap_internal(strap_int));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic check(string what, logic seen, logic exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic note(string what, int idx, logic exp);
    notes.push_back('{what, idx, exp});
    ->look;
  endtask : note
  task automatic cyc(int k);
    repeat (k) @(negedge clk);
  endtask : cyc
  // Bounded wait; a timeout shows up as a mismatch in the next note
  task automatic wait_for(int idx, logic val);
    for (int k = 0; k < 20 && obs[idx] !== val; k++) @(negedge clk);
  endtask : wait_for
  task automatic do_reset(logic s);
    rst = 1;
    strap = s;
    cyc(20);
    rst = 0;
    cyc(4);
  endtask : do_reset
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // Monitor: every queued note, oldest first, against what the outputs show now
  // ------------------------------------------------------------
  always begin
    @(look);
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(n.what, obs[n.idx], n.exp);
    end
  end

  // Hang guard, far beyond the roughly 130 cycles needed
  initial begin
    #50000;
    errors++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    cyc(1);
    do_reset(1'b1);
    note("strap_int", 0, 1'b1);
    note("io_free", 1, 1'b1);
    // Range edges then random; strap pin moves midway and must not count
    for (int i = 0; i < 8; i++) begin
      req.valid = 1'b1;
      req.addr = (i == 0) ? 24'hFF2000 : (i == 1) ? 24'hFF9FFF :
        24'hFF2000 + 24'(xs() % 32'h8000);
      if (i == 2) strap = 1'b0;
      cyc(1);
      note("to_int", 7, 1'b1);
      note("to_ext", 6, 1'b0);
    end
    // Just outside the range the latched strap is ignored
    for (int i = 0; i < 2; i++) begin
      req.addr = (i == 0) ? 24'hFF1FFF : 24'hFFA000;
      cyc(1);
      note("out_int", 7, 1'b0);
      note("out_ext", 6, 1'b1);
    end
    req.valid = 1'b0;
    do_reset(1'b0);
    note("strap_low", 0, 1'b0);
    note("io_locked", 1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      req.valid = 1'b1;
      req.addr = 24'hFF2000 + 24'(xs() % 32'h8000);
      cyc(1);
      note("ext_to_ext", 6, 1'b1);
    end
    req.valid = 1'b0;
    // Request refused with enable bit clear, then with pin not special
    win = 8'h7F;
    want = 1;
    cyc(8);
    note("ack_off_bit", 5, 1'b1);
    win = 8'h80;
    special = 0;
    cyc(8);
    note("ack_off_pin", 5, 1'b1);
    // Pin must be back high before the pin is made special again
    want = 0;
    cyc(6);
    special = 1;
    cyc(2);
    // Internal execution: pending cycle and irq while held
    want = 1;
    wait_for(5, 1'b0);
    note("ack_low", 5, 1'b0);
    note("bus_float", 2, 1'b0);
    req.valid = 1'b1;
    req.addr = 24'h000100;
    wait_for(4, 1'b0);
    note("need_low", 4, 1'b0);
    irq = 1;
    cyc(1);
    note("irq_now", 3, 1'b0);
    want = 0;
    cyc(1);
    note("need_stays", 4, 1'b0);
    wait_for(5, 1'b1);
    note("need_gone", 4, 1'b1);
    note("oe_after_ack", 2, 1'b0);
    cyc(1);
    note("oe_back", 2, 1'b1);
    req.valid = 1'b0;
    irq = 0;
    cyc(4);
    // External execution: irq while held defers irq-out
    ext = 1;
    want = 1;
    wait_for(5, 1'b0);
    irq = 1;
    cyc(2);
    note("need_irq", 4, 1'b0);
    note("irq_wait", 3, 1'b1);
    want = 0;
    cyc(1);
    note("irq_wait2", 3, 1'b1);
    wait_for(5, 1'b1);
    note("irq_late", 3, 1'b0);
    irq = 0;
    cyc(4);
    // Irq while going into hold, own cycle still in flight
    req.cycle_busy = 1'b1;
    want = 1;
    cyc(4);
    irq = 1;
    cyc(1);
    note("ack_busy", 5, 1'b1);
    req.cycle_busy = 1'b0;
    wait_for(5, 1'b0);
    note("irq_with_ack", 3, 1'b0);
    cyc(3);
    note("ack_kept", 5, 1'b0);
    note("irq_kept", 3, 1'b0);
    want = 0;
    wait_for(5, 1'b1);
    note("ack_freed", 5, 1'b1);
    cyc(2);
    wrap_up();
  end
endmodule : bus_hold_arbitration_test
